// *** logic/rst_seq_pkg.sv ***
package rst_seq_pkg;
	localparam int clk_period_ns = 50;
	localparam int min_width_cycles = 4;
	localparam int stretch_cycles = 4096;
	localparam int lock_delay_cycles = 2;
	localparam int pll_relock_us = 100;
	localparam int pll_relock_cycles = (pll_relock_us * 1000) / clk_period_ns;
	localparam int cfg_width = 16;
	localparam int cnt_width = 13;
	localparam logic [cfg_width-1:0] cfg_reset = 16'h0000;
endpackage

// *** logic/reset_sync.sv ***
// two-flop synchroniser for one asynchronous level
module reset_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic din,
	output logic dout
);
	logic meta_q;
	always_ff @(posedge clk) begin
		// held asserted while the logic itself is in reset
		if (rst) begin
			meta_q <= 1'b0;
			dout <= 1'b0;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule

// *** logic/reset_sequence_and_config_latch.sv ***
// reset front end: width check, stretch and strap capture
module reset_sequence_and_config_latch #(
	parameter int stretch = rst_seq_pkg::stretch_cycles,
	parameter int cfg_w = rst_seq_pkg::cfg_width
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic power_on_reset_pin_n,
	input wire logic hard_reset_pin_n_in,
	output logic hard_reset_pin_n_out,
	output logic hard_reset_pin_oe,
	input wire logic soft_reset_pin_n_in,
	output logic soft_reset_pin_n_out,
	output logic soft_reset_pin_oe,
	input wire logic [cfg_w-1:0] cfg_strap,
	output logic [cfg_w-1:0] cfg_word_q,
	output logic cfg_locked_q,
	output logic int_hard_reset_q,
	output logic int_soft_reset_q
);
	import rst_seq_pkg::*;

	// the counter width limits the stretch to 2**cnt_width-1 cycles
	localparam logic [cnt_width-1:0] stretch_load =
		cnt_width'(stretch);
	localparam logic [2:0] min_w = 3'(min_width_cycles);
	localparam logic [1:0] lock_d = 2'(lock_delay_cycles);

	logic por_s;
	logic hrd_s;
	logic srt_s;
	logic [cfg_w-1:0] strap_m_q;
	logic [cfg_w-1:0] strap_s_q;
	logic [2:0] hrd_w_q;
	logic [2:0] srt_w_q;
	logic [cnt_width-1:0] pstr_q;
	logic [cnt_width-1:0] hstr_q;
	logic [cnt_width-1:0] sstr_q;
	logic [1:0] lock_q;
	logic hrd_prev_q;
	logic srt_prev_q;
	logic por_hold;
	logic hard_hold;
	logic soft_hold;
	logic sampling;
	logic lock_run;

	// counts synchronised low cycles, saturating at the minimum width
	function automatic logic [2:0] wcount(input logic low,
			input logic [2:0] c);
		if (!low)
			return 3'h0;
		return (c == min_w) ? c : c + 3'h1;
	endfunction

	// stretch counter step, holding at zero
	function automatic logic [cnt_width-1:0] dec(
			input logic [cnt_width-1:0] c);
		return (c == '0) ? c : c - cnt_width'(1);
	endfunction

	function automatic logic busy(input logic [cnt_width-1:0] c);
		return c != '0;
	endfunction

	// release of an assertion that met the minimum width
	function automatic logic valid_rise(input logic now,
			input logic prev, input logic [2:0] w);
		return now && !prev && w == min_w;
	endfunction

	assign por_hold = !por_s || busy(pstr_q);
	assign hard_hold = hrd_w_q == min_w || busy(hstr_q);
	assign soft_hold = srt_w_q == min_w || busy(sstr_q);
	// own drive on the hard pin counts too, so straps keep flowing
	assign sampling = !por_s || !hrd_s;
	assign lock_run = lock_q != lock_d;

	// resets are asynchronous pins; each is synchronised first
	reset_sync u_por (.clk(clk), .rst(rst), .din(power_on_reset_pin_n),
		.dout(por_s));
	reset_sync u_hrd (.clk(clk), .rst(rst), .din(hard_reset_pin_n_in),
		.dout(hrd_s));
	reset_sync u_srt (.clk(clk), .rst(rst), .din(soft_reset_pin_n_in),
		.dout(srt_s));

	// straps pass two flops too; they must be static while captured
	always_ff @(posedge clk) begin
		if (rst) begin
			strap_m_q <= cfg_reset;
			strap_s_q <= cfg_reset;
		end else begin
			strap_m_q <= cfg_strap;
			strap_s_q <= strap_m_q;
		end
	end

	// low-width counter for the hard input
	always_ff @(posedge clk) begin
		if (rst)
			hrd_w_q <= 3'h0;
		else
			hrd_w_q <= wcount(!hrd_s, hrd_w_q);
	end

	// low-width counter for the soft input
	always_ff @(posedge clk) begin
		if (rst)
			srt_w_q <= 3'h0;
		else
			srt_w_q <= wcount(!srt_s, srt_w_q);
	end

	// previous hard level for release detection
	always_ff @(posedge clk) begin
		if (rst)
			hrd_prev_q <= 1'b0;
		else
			hrd_prev_q <= hrd_s;
	end

	// previous soft level for release detection
	always_ff @(posedge clk) begin
		if (rst)
			srt_prev_q <= 1'b0;
		else
			srt_prev_q <= srt_s;
	end

	// power-on stretch drives both pins low after release
	always_ff @(posedge clk) begin
		if (rst)
			pstr_q <= stretch_load;
		else if (!por_s)
			pstr_q <= stretch_load;
		else
			pstr_q <= dec(pstr_q);
	end

	// hard stretch starts on release of a valid-width assertion
	always_ff @(posedge clk) begin
		if (rst)
			hstr_q <= '0;
		else if (valid_rise(hrd_s, hrd_prev_q, hrd_w_q))
			hstr_q <= stretch_load;
		else
			hstr_q <= dec(hstr_q);
	end

	// soft stretch likewise
	always_ff @(posedge clk) begin
		if (rst)
			sstr_q <= '0;
		else if (valid_rise(srt_s, srt_prev_q, srt_w_q))
			sstr_q <= stretch_load;
		else
			sstr_q <= dec(sstr_q);
	end

	// hard pin drive during the power-on stretch
	always_ff @(posedge clk) begin
		if (rst)
			hard_reset_pin_oe <= 1'b1;
		else
			hard_reset_pin_oe <= por_hold;
	end

	// soft pin drive during the power-on stretch
	always_ff @(posedge clk) begin
		if (rst)
			soft_reset_pin_oe <= 1'b1;
		else
			soft_reset_pin_oe <= por_hold;
	end

	// the pins are only ever pulled low
	always_ff @(posedge clk) begin
		if (rst) begin
			hard_reset_pin_n_out <= 1'b0;
			soft_reset_pin_n_out <= 1'b0;
		end else begin
			hard_reset_pin_n_out <= 1'b0;
			soft_reset_pin_n_out <= 1'b0;
		end
	end

	// internal hard reset
	always_ff @(posedge clk) begin
		if (rst)
			int_hard_reset_q <= 1'b1;
		else
			int_hard_reset_q <= por_hold || hard_hold;
	end

	// soft reset covers every hard reset cause as well
	always_ff @(posedge clk) begin
		if (rst)
			int_soft_reset_q <= 1'b1;
		else
			int_soft_reset_q <= por_hold || hard_hold || soft_hold;
	end

	// lock delay counter, restarted by a power-on or hard reset assertion (not by soft)
	always_ff @(posedge clk) begin
		if (rst)
			lock_q <= 2'h0;
		else if (sampling)
			lock_q <= 2'h0;
		else if (lock_run)
			lock_q <= lock_q + 2'h1;
	end

	// lock flag rises with the last capture
	always_ff @(posedge clk) begin
		if (rst)
			cfg_locked_q <= 1'b0;
		else if (sampling)
			cfg_locked_q <= 1'b0;
		else if (lock_run)
			cfg_locked_q <= (lock_q + 2'h1) == lock_d;
	end

	// word follows the straps until the lock delay has run out
	always_ff @(posedge clk) begin
		if (rst)
			cfg_word_q <= cfg_reset;
		else if (sampling)
			cfg_word_q <= strap_s_q;
		else if (lock_run)
			cfg_word_q <= strap_s_q;
	end
endmodule

// *** verification/rst_seq_props.sv ***
module rst_seq_props #(
	parameter int stretch = 16,
	parameter int cfg_w = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic power_on_reset_pin_n,
	input wire logic hard_reset_pin_n_in,
	input wire logic hard_reset_pin_n_out,
	input wire logic hard_reset_pin_oe,
	input wire logic soft_reset_pin_n_out,
	input wire logic soft_reset_pin_oe,
	input wire logic [cfg_w-1:0] cfg_strap,
	input wire logic [cfg_w-1:0] cfg_word_q,
	input wire logic cfg_locked_q,
	input wire logic int_hard_reset_q,
	input wire logic int_soft_reset_q
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	drive_low_a: assert property (
		hard_reset_pin_oe |-> !hard_reset_pin_n_out)
		else $error("hard pin driven high");
	soft_drive_a: assert property (
		soft_reset_pin_oe |-> !soft_reset_pin_n_out)
		else $error("soft pin driven high");
	por_drive_a: assert property (
		!power_on_reset_pin_n [*4] |->
		hard_reset_pin_oe && soft_reset_pin_oe && !cfg_locked_q)
		else $error("no drive in power-on");
	drive_hold_a: assert property (
		$fell(hard_reset_pin_oe) |->
		$past(power_on_reset_pin_n, stretch))
		else $error("drive short");
	strap_take_a: assert property (
		(!power_on_reset_pin_n && $stable(cfg_strap)) [*4] |->
		cfg_word_q == cfg_strap)
		else $error("strap not taken");
	word_frozen_a: assert property (
		cfg_locked_q && $past(cfg_locked_q) |-> $stable(cfg_word_q))
		else $error("word moved");
	lock_after_a: assert property (
		(power_on_reset_pin_n && hard_reset_pin_n_in) [*6] |->
		cfg_locked_q)
		else $error("no lock");
	int_stretch_a: assert property (
		$fell(int_hard_reset_q) |->
		$past(hard_reset_pin_n_in, stretch))
		else $error("stretch short");
	soft_incl_a: assert property (
		int_hard_reset_q |-> int_soft_reset_q)
		else $error("soft misses hard");
endmodule
bind reset_sequence_and_config_latch rst_seq_props #(.stretch(stretch),
	.cfg_w(cfg_w)) props_u (.*);

// *** verification/board_supervisor.sv ***
module board_supervisor (
	input wire logic clk,
	output logic por_n,
	output logic hard_n,
	output logic soft_n,
	output logic [15:0] strap
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{por_n, hard_n, soft_n, strap} = {3'h3, 16'h0000};
	end
	// power-up: power-on held low past the pll relock time
	task automatic power_on(input logic [15:0] cfg);
		strap = cfg;
		repeat (rst_seq_pkg::pll_relock_cycles)
			@(negedge clk);
		por_n = 1'b1;
	endtask
	// straps move only to prove capture and freeze
	task automatic set_strap(input logic [15:0] cfg);
		@(negedge clk);
		strap = cfg;
	endtask
	// glitch-free low pulse: 0 power-on, 1 hard, 2 soft
	task automatic pulse(input int sel, input int n);
		@(negedge clk);
		if (sel == 0) por_n = 1'b0;
		else if (sel == 1) hard_n = 1'b0;
		else soft_n = 1'b0;
		repeat (n) @(negedge clk);
		{por_n, hard_n, soft_n} = 3'h7;
	endtask
endmodule

// *** verification/reset_sequence_and_config_latch_tb.sv ***
module reset_sequence_and_config_latch_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic por_n, hard_n, soft_n, h_out, h_oe, s_out, s_oe;
	logic lk, i_hard, i_soft;
	logic [15:0] strap, word;
	int errors = 0;
	int n_tests = 0;
	wire hard_w = hard_n && !(h_oe && !h_out);
	wire soft_w = soft_n && !(s_oe && !s_out);
	initial forever #25 clk = ~clk;
	board_supervisor sup_u (.clk(clk), .por_n(por_n), .hard_n(hard_n),
		.soft_n(soft_n), .strap(strap));
	reset_sequence_and_config_latch #(.stretch(16)) dut_u (.clk(clk),
		.rst(rst), .power_on_reset_pin_n(por_n), .hard_reset_pin_n_in(hard_w),
		.hard_reset_pin_n_out(h_out), .hard_reset_pin_oe(h_oe),
		.soft_reset_pin_n_in(soft_w), .soft_reset_pin_n_out(s_out),
		.soft_reset_pin_oe(s_oe), .cfg_strap(strap), .cfg_word_q(word),
		.cfg_locked_q(lk), .int_hard_reset_q(i_hard),
		.int_soft_reset_q(i_soft));
	task check(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task complete_run;
		$display("errors %0d n_tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task power_up;
		sup_u.power_on(16'h5a3c);
		check(word, 16'h5a3c);
		check(lk, 1'b0);
		repeat (12) @(negedge clk);
		check({h_oe, s_oe, i_hard}, 3'h7);
		repeat (20) @(negedge clk);
		check({h_oe, s_oe, lk}, 3'h1);
		sup_u.set_strap(16'h00ff);
		repeat (6) @(negedge clk);
		check(word, 16'h5a3c);
	endtask
	task pulse_case(input int sel, input int n, input logic exp);
		sup_u.pulse(sel, n);
		repeat (10) @(negedge clk);
		check(sel == 1 ? i_hard : i_soft, exp);
		repeat (30) @(negedge clk);
		check({i_soft, lk}, 2'h1);
	endtask
	task hard_recapture;
		sup_u.set_strap(16'h1234);
		pulse_case(1, 6, 1'b1);
		check(word, 16'h1234);
	endtask
	task por_again;
		sup_u.set_strap(16'h3c5a);
		sup_u.pulse(0, 6);
		repeat (10) @(negedge clk);
		check({h_oe, s_oe, i_hard}, 3'h7);
		repeat (50) @(negedge clk);
		check({h_oe, i_hard, lk}, 3'h1);
		check(word, 16'h3c5a);
	endtask
	initial begin
		repeat (4) @(negedge clk);
		rst = 1'b0;
		power_up;
		pulse_case(1, 2, 1'b0);
		pulse_case(2, 2, 1'b0);
		pulse_case(2, 6, 1'b1);
		hard_recapture;
		por_again;
		complete_run;
	end
	// tests need about 120 us, most of it the power-up hold
	initial begin
		#300000;
		errors++;
		complete_run;
	end
endmodule
